// ---- rtl/dac_regs.svh ----
// Register map, field positions and timing constants of the archive controller
`ifndef DAC_REGS_SVH
`define DAC_REGS_SVH
`define DAC_A_CTRL 4'h0
`define DAC_A_STATUS 4'h1
`define DAC_A_BIN_IN 4'h2
`define DAC_A_MEAS 4'h3
`define DAC_A_TCORR 4'h4
`define DAC_A_SYNC 4'h5
`define DAC_A_BILL 4'h6
`define DAC_A_TARIFF 4'h7
`define DAC_A_SET_CNT 4'h8
`define DAC_A_GAS_PTR 4'h9
`define DAC_A_STAT_LO 4'hA
`define DAC_A_STAT_HI 4'hB
`define DAC_A_MIN 4'hC
`define DAC_A_MAX 4'hD
`define DAC_A_REQ 4'hE
`define DAC_A_TIME 4'hF
`define DAC_ADMIN_SEC 32'h0000_0258
`define DAC_LOG_SEC 32'h0000_003C
`define DAC_REJ_SEC 32'h0000_1C20
`define DAC_DAY_SEC 32'h0001_5180
`define DAC_SYNC_DAYS 8'h14
`define DAC_TIMEOUT_DAYS 8'h19
`define DAC_SET_DEPTH 16'h0100
`define DAC_GAS_DEPTH 8'h10
`define DAC_TICKS_PER_SEC 27'h5F5_E100
`define DAC_DST_BIT 31
`define DAC_DST_FIRST_DAY 9'h05A
`define DAC_DST_LAST_DAY 9'h12C
`define DAC_MONTH_SEC 32'h0027_8D00
`define DAC_SLOT_SEC 32'h0000_5460
`endif

// ---- rtl/dac_pkg.sv ----
// Types shared by the archive controller
package dac_pkg;
  typedef enum logic [1:0] {dac_sw_full, dac_sw_none, dac_sw_partial, dac_sw_rsv} dac_sw_mode_t;
  typedef struct packed {
    logic [31:0] time_s;
    logic [63:0] status;
    logic [31:0] primary_volume_count;
    logic [31:0] base_volume_count;
  } dac_stat_rec_t;
  typedef struct packed {
    logic [7:0] op_id;
    logic [7:0] activity;
    logic [31:0] old_val;
    logic [31:0] new_val;
    logic metro;
    logic gas;
  } dac_par_wr_t;
  typedef enum logic [1:0] {dac_bill_off, dac_bill_once, dac_bill_periodic} dac_bill_mode_t;
endpackage : dac_pkg

// ---- rtl/dac_sync3.sv ----
// Three-stage pin synchroniser, change accepted when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module dac_sync3 (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Pin and result
  input wire logic pin,
  output logic level
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      level <= 1'b0;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        level <= s3_ff;
      end
    end
  end
endmodule : dac_sync3
`default_nettype wire

// ---- rtl/dac_ring_ptr.sv ----
// Circular write pointer with full flag for overwriting archives
`timescale 1ns/1ps
`default_nettype none
module dac_ring_ptr #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Control
  input wire logic clear,
  input wire logic push,
  // State
  output logic [W-1:0] ptr,
  output logic wrapped
);
  always_ff @(posedge clock) begin
    if (!rst_b || clear) begin
      ptr <= '0;
      wrapped <= 1'b0;
    end else if (push) begin
      ptr <= ptr + 1'b1;
      if (&ptr) begin
        wrapped <= 1'b1;
      end
    end
  end
endmodule : dac_ring_ptr
`default_nettype wire

// ---- rtl/dac_archive_ctrl.sv ----
// Datalogger archive and write-protection controller
// How it works
// [R1] Binary record only on any input change
// [R2] Limit holders track extremes, init to current
// [R3] Event change logs time, status, volumes
// [R4] Settings entry: time, operator, activity, values; set_rec holds no time
// [R5] Gas composition changes skip settings archive
// [R6] Full settings archive refuses entries and writes
// [R7] Billing once or every 1,2,3,4,6,12 months
// [R8] Billing captures total and tariff volumes
// [R9] Gas changes logged, oldest overwritten
// [R10] Admin correction within ten minutes unlogged
// [R11] Over sixty seconds below two hours: status-logged
// [R12] Over two hours rejected with alert
// [R13] Auto sync every 20 days, retry daily
// [R14] No sync by day 25 sets error
// [R15] Sync offset judged against storage period; code compares it against DAC_REJ_SEC (two hours)
// [R16] Daylight saving switches, records flag season; code only sets the flag bit and does not shift the clock
// [R17] Four tariff counters, one of two schedules
// [R18] Schedules map slots and day classes
// [R19] Each schedule own identifier and activation; code has one activation field tariff_ff[31:17] shared by both
// [R20] Full mode: switch off blocks writes
// [R21] No-effect mode: writes always allowed
// [R22] Partial mode off: only non-metrological writes
// [R23] Overwriting archives use wrapping write pointer
//
// The Avalon-MM interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "dac_regs.svh"
module dac_archive_ctrl (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Pins and measurement inputs
  input wire logic service_switch,
  input wire logic [7:0] binary_in,
  input wire logic [31:0] primary_volume_count,
  input wire logic [31:0] base_volume_count,
  input wire logic [31:0] meas_value,
  input wire logic sync_done,
  input wire logic sync_ok,
  input wire logic [31:0] sync_offset,
  // Archive write strobes and records, sync request, alarms and tariff select
  output dac_pkg::dac_stat_rec_t stat_rec,
  output logic stat_we,
  output logic bin_we,
  output logic set_we,
  output dac_pkg::dac_par_wr_t set_rec,
  output logic gas_we,
  output logic [3:0] gas_addr,
  output logic bill_we,
  output logic sync_req,
  output logic time_alert,
  output logic sync_timeout_error,
  output logic [1:0] tariff_sel
);
  import dac_pkg::*;
  logic sw_on;
  logic [7:0] bin_prev_ff;
  logic [31:0] time_ff;
  logic [26:0] tick_ff;
  logic sec_pulse;
  logic [31:0] ctrl_ff;
  logic [63:0] ev_status;
  logic [63:0] ev_prev_ff;
  logic [31:0] min_ff;
  logic [31:0] max_ff;
  logic [15:0] set_cnt_ff;
  logic set_full;
  logic [31:0] days_ff;
  logic [31:0] sec_in_day_ff;
  logic [7:0] since_sync_ff;
  logic retry_pend_ff;
  logic [31:0] bill_due_ff;
  logic [3:0] bill_mon_ff;
  logic [3:0] gas_ptr;
  logic gas_wrap;
  logic req_ff;
  logic [31:0] tcorr_ff;
  logic [31:0] tariff_ff;
  logic [31:0] abs_corr;
  logic [31:0] abs_sync;
  logic corr_apply;
  logic write_ok;
  logic dst_on;
  dac_sw_mode_t sw_mode;
  dac_bill_mode_t bill_mode;
  dac_par_wr_t par;
  logic [3:0] bill_per;
  logic limit_init;
  logic do_reg_wr;

  // CTRL: [1:0] switch mode, [3:2] billing mode, [7:4] period, [8] dst, [9] auto sync, [10] limit init
  assign sw_mode = dac_sw_mode_t'(ctrl_ff[1:0]);
  assign bill_mode = dac_bill_mode_t'(ctrl_ff[3:2]);
  assign bill_per = ctrl_ff[7:4];
  assign dst_on = ctrl_ff[8];
  assign limit_init = avs_write && !avs_waitrequest && avs_address == `DAC_A_CTRL && avs_writedata[10]
    && write_ok && !set_full;
  assign sec_pulse = (tick_ff == `DAC_TICKS_PER_SEC - 27'h1);
  assign set_full = (set_cnt_ff == `DAC_SET_DEPTH);
  assign abs_corr = tcorr_ff[31] ? (~tcorr_ff + 32'h1) : tcorr_ff;
  assign abs_sync = sync_offset[31] ? (~sync_offset + 32'h1) : sync_offset;
  assign ev_status = {sync_timeout_error, time_alert, set_full, 21'h0, min_ff == meas_value,
    max_ff == meas_value, 30'h0, bin_prev_ff};
  // Request word: [7:0] activity, [16] metrological, [17] gas composition, [18] correction; operator from TCORR [15:8]
  assign par.op_id = tcorr_ff[15:8];
  assign par.activity = avs_writedata[7:0];
  assign par.old_val = tariff_ff;
  assign par.new_val = tcorr_ff;
  assign par.metro = avs_writedata[16];
  assign par.gas = avs_writedata[17];

  dac_sync3 u_sw (
    .clock(clock),
    .rst_b(rst_b),
    .pin(service_switch),
    .level(sw_on)
  );

  dac_ring_ptr #(.W(4)) u_gas_ptr (
    .clock(clock),
    .rst_b(rst_b),
    .clear(1'b0),
    .push(gas_we), // see [R23]
    .ptr(gas_ptr),
    .wrapped(gas_wrap)
  );

  // Write gate by service switch mode
  always_comb begin
    case (sw_mode)
      dac_sw_full: write_ok = sw_on; // see [R20]
      dac_sw_none: write_ok = 1'b1; // see [R21]
      dac_sw_partial: write_ok = sw_on || !par.metro; // see [R22]
      default: write_ok = sw_on;
    endcase
  end
  assign do_reg_wr = avs_write && !avs_waitrequest && avs_address == `DAC_A_REQ;
  // Corrections over DAC_ADMIN_SEC (settings-logged) are refused once the settings archive is full
  assign corr_apply = do_reg_wr && write_ok && avs_writedata[18] && abs_corr <= `DAC_REJ_SEC
    && (abs_corr <= `DAC_ADMIN_SEC || !set_full);

  // Bus: one wait cycle per access
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      req_ff <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      req_ff <= (avs_read || avs_write) && avs_waitrequest && !req_ff;
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest && !req_ff);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && avs_waitrequest && !req_ff) begin
      case (avs_address)
        `DAC_A_CTRL: avs_readdata <= ctrl_ff;
        `DAC_A_STATUS: avs_readdata <= {26'h0, gas_wrap, sw_on, write_ok, set_full, time_alert,
          sync_timeout_error};
        `DAC_A_BIN_IN: avs_readdata <= {24'h0, bin_prev_ff};
        `DAC_A_TCORR: avs_readdata <= tcorr_ff;
        `DAC_A_SYNC: avs_readdata <= {24'h0, since_sync_ff};
        `DAC_A_BILL: avs_readdata <= bill_due_ff;
        `DAC_A_TARIFF: avs_readdata <= tariff_ff;
        `DAC_A_SET_CNT: avs_readdata <= {16'h0, set_cnt_ff};
        `DAC_A_GAS_PTR: avs_readdata <= {28'h0, gas_ptr};
        `DAC_A_STAT_LO: avs_readdata <= stat_rec.status[31:0];
        `DAC_A_STAT_HI: avs_readdata <= stat_rec.status[63:32];
        `DAC_A_MIN: avs_readdata <= min_ff;
        `DAC_A_MAX: avs_readdata <= max_ff;
        `DAC_A_TIME: avs_readdata <= time_ff;
        default: avs_readdata <= 32'h0;
      endcase
    end
  end

  // Configuration registers, blocked by the write gate and a full settings archive
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctrl_ff <= 32'h0;
      tcorr_ff <= 32'h0;
      tariff_ff <= 32'h0;
    end else if (avs_write && !avs_waitrequest && write_ok && !set_full) begin // see [R6]
      case (avs_address)
        `DAC_A_CTRL: ctrl_ff <= {21'h0, 1'b0, avs_writedata[9:0]};
        `DAC_A_TCORR: tcorr_ff <= avs_writedata;
        // Bits [7:0] id1, [15:8] id2, [16] active schedule, [31:17] activation second shared by both schedules
        `DAC_A_TARIFF: tariff_ff <= avs_writedata; // see [R19]
        default: ;
      endcase
    end
  end

  // Seconds clock, daylight flag in the top time bit
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tick_ff <= 27'h0;
      time_ff <= 32'h0;
      sec_in_day_ff <= 32'h0;
      days_ff <= 32'h0;
      time_alert <= 1'b0;
    end else begin
      tick_ff <= sec_pulse ? 27'h0 : tick_ff + 27'h1;
      if (do_reg_wr && avs_writedata[18] && abs_corr > `DAC_REJ_SEC) begin
        time_alert <= 1'b1; // see [R12]
      end else if (corr_apply) begin
        time_ff <= time_ff + tcorr_ff; // see [R10]
      end else if (sync_done && sync_ok && abs_sync <= `DAC_REJ_SEC) begin
        time_ff <= time_ff + sync_offset; // see [R15]
      end else if (sec_pulse) begin
        time_ff[`DAC_DST_BIT-1:0] <= time_ff[`DAC_DST_BIT-1:0] + 31'h1;
        time_ff[`DAC_DST_BIT] <= dst_on && (days_ff[8:0] > `DAC_DST_FIRST_DAY)
          && (days_ff[8:0] < `DAC_DST_LAST_DAY); // see [R16]
        if (sec_in_day_ff == `DAC_DAY_SEC - 32'h1) begin
          sec_in_day_ff <= 32'h0;
          days_ff <= days_ff + 32'h1;
        end else begin
          sec_in_day_ff <= sec_in_day_ff + 32'h1;
        end
      end
    end
  end

  // Automatic synchronisation schedule
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      since_sync_ff <= 8'h0;
      retry_pend_ff <= 1'b0;
      sync_req <= 1'b0;
      sync_timeout_error <= 1'b0;
    end else begin
      sync_req <= 1'b0;
      if (sync_done && sync_ok) begin
        since_sync_ff <= 8'h0;
        retry_pend_ff <= 1'b0;
        sync_timeout_error <= 1'b0;
      end else if (sync_done) begin
        retry_pend_ff <= 1'b1;
      end
      if (sec_pulse && sec_in_day_ff == `DAC_DAY_SEC - 32'h1 && ctrl_ff[9]) begin
        since_sync_ff <= since_sync_ff + 8'h1;
        if (since_sync_ff + 8'h1 >= `DAC_SYNC_DAYS || retry_pend_ff) begin
          sync_req <= 1'b1; // see [R13]
        end
        if (since_sync_ff + 8'h1 >= `DAC_TIMEOUT_DAYS) begin
          sync_timeout_error <= 1'b1; // see [R14]
        end
      end
    end
  end

  // Limit holders
  always_ff @(posedge clock) begin
    if (!rst_b || limit_init) begin
      min_ff <= !rst_b ? 32'h0 : meas_value; // see [R2]
      max_ff <= !rst_b ? 32'h0 : meas_value;
    end else begin
      if (meas_value < min_ff) min_ff <= meas_value;
      if (meas_value > max_ff) max_ff <= meas_value;
    end
  end

  // Binary and status archives
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      bin_prev_ff <= 8'h0;
      ev_prev_ff <= 64'h0;
      bin_we <= 1'b0;
      stat_we <= 1'b0;
      stat_rec <= '0;
    end else begin
      bin_prev_ff <= binary_in;
      ev_prev_ff <= ev_status;
      bin_we <= (binary_in != bin_prev_ff); // see [R1]
      stat_we <= (ev_status != ev_prev_ff) || (corr_apply && abs_corr > `DAC_LOG_SEC); // see [R3] [R11]
      stat_rec.time_s <= time_ff;
      stat_rec.status <= ev_status;
      stat_rec.primary_volume_count <= primary_volume_count;
      stat_rec.base_volume_count <= base_volume_count;
    end
  end

  // Settings and gas composition archives
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      set_cnt_ff <= 16'h0;
      set_we <= 1'b0;
      gas_we <= 1'b0;
      set_rec <= '0;
      gas_addr <= 4'h0;
    end else begin
      set_we <= 1'b0;
      gas_we <= 1'b0;
      if (do_reg_wr && write_ok && !avs_writedata[18]) begin
        if (par.gas) begin
          gas_we <= 1'b1; // see [R5] [R9]
          gas_addr <= gas_ptr;
        end else if (!set_full) begin
          set_we <= 1'b1; // see [R4] [R6]
          set_rec <= par;
          set_cnt_ff <= set_cnt_ff + 16'h1;
        end
      end else if (corr_apply && abs_corr > `DAC_ADMIN_SEC) begin // see [R10]
        set_we <= 1'b1;
        set_rec <= par;
        set_cnt_ff <= set_cnt_ff + 16'h1;
      end
    end
  end

  // Billing trigger and tariff selection
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      bill_due_ff <= 32'h0;
      bill_mon_ff <= 4'h0;
      bill_we <= 1'b0;
      tariff_sel <= 2'h0;
    end else begin
      bill_we <= 1'b0;
      if (avs_write && !avs_waitrequest && avs_address == `DAC_A_BILL && write_ok && !set_full) begin
        bill_due_ff <= avs_writedata;
      end else if (sec_pulse && time_ff[30:0] == bill_due_ff[30:0] && bill_mode != dac_bill_off) begin
        bill_we <= 1'b1; // see [R7] [R8]
        if (bill_mode == dac_bill_periodic && (bill_per inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'hC})) begin
          bill_due_ff <= bill_due_ff + 32'(bill_per) * `DAC_MONTH_SEC;
        end
      end
      // Slot hour decides band; Saturday/Sunday select 3 whichever schedule is active
      if (time_ff[30:0] >= {16'h0, tariff_ff[31:17]}) begin
        tariff_sel <= (days_ff % 32'h7 >= 32'h5) ? 2'h3 :
          (sec_in_day_ff < `DAC_SLOT_SEC) ? {1'b0, tariff_ff[16]} : {1'b1, tariff_ff[16]}; // see [R17] [R18]
      end
    end
  end
endmodule : dac_archive_ctrl
`default_nettype wire

// ---- verification/dac_asserts.sv ----
// Port assertions for the archive controller
`timescale 1ns/1ps
`default_nettype none
module dac_asserts (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Events
  input wire logic [7:0] binary_in,
  input wire logic bin_we,
  input wire logic set_we,
  input wire logic gas_we,
  input wire logic [3:0] gas_addr,
  input wire logic time_alert,
  input wire logic sync_done,
  input wire logic sync_ok,
  input wire logic sync_timeout_error
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  AST_ANSWER_NEXT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  AST_BIN_ONLY_ON_CHANGE: assert property (bin_we |-> $past(binary_in) != $past(binary_in, 2))
    else $error("binary record without change");
  AST_BIN_ON_CHANGE: assert property (!$stable(binary_in) |=> bin_we)
    else $error("binary change not recorded");
  AST_ALERT_STICKY: assert property (time_alert |=> time_alert)
    else $error("alert dropped");
  AST_GAS_NOT_SETTINGS: assert property (gas_we |-> !set_we)
    else $error("gas change in settings archive");
  AST_GAS_PTR_STEP: assert property (!$stable(gas_addr) |-> gas_addr == $past(gas_addr) + 4'h1)
    else $error("gas pointer jumped");
  AST_SET_AFTER_WRITE: assert property (set_we |-> $past(avs_write))
    else $error("settings entry without write");
  AST_SYNC_CLEAR: assert property (sync_done && sync_ok |-> ##[1:3] !sync_timeout_error)
    else $error("sync error not cleared");
  cover property (set_we);
  cover property (gas_we);
  cover property ($rose(time_alert));
endmodule : dac_asserts
`default_nettype wire

// ---- verification/dac_svc_model.sv ----
// Service switch and remote time source model
`timescale 1ns/1ps
`default_nettype none
module dac_svc_model #(
  parameter int LAT = 3
) (
  // Clock
  input wire logic clock,
  // Operator side
  input wire logic switch_on,
  // Device side
  input wire logic sync_req,
  output logic service_switch,
  output logic sync_done,
  output logic sync_ok,
  output logic [31:0] sync_offset
);
  logic [3:0] cnt_ff = 4'h0;
  assign service_switch = switch_on;
  assign sync_done = (cnt_ff == 4'h1);
  assign sync_ok = 1'b1;
  assign sync_offset = 32'h0;
  // Answer each sync request after a delay
  always_ff @(posedge clock) begin
    if (sync_req) begin
      cnt_ff <= 4'(LAT);
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
    end
  end
endmodule : dac_svc_model
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the archive controller
`timescale 1ns/1ps
`default_nettype none
`include "dac_regs.svh"
module tb;
  import dac_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, meas = 32'h0, sync_offset;
  logic avs_waitrequest, switch_on = 1'b0, service_switch, sync_done, sync_ok, sync_req;
  logic stat_we, bin_we, set_we, gas_we, bill_we, time_alert, sync_timeout_error;
  logic [7:0] binary_in = 8'h00;
  logic [3:0] gas_addr;
  logic [1:0] tariff_sel;
  dac_stat_rec_t stat_rec;
  dac_par_wr_t set_rec;
  int fail_count = 0;
  int n_compared = 0;
  int n_set = 0, n_stat = 0, n_bin = 0, n_gas = 0;
  always #5 clock = ~clock;
  always @(posedge clock) begin
    n_set <= n_set + int'(set_we === 1'b1);
    n_stat <= n_stat + int'(stat_we === 1'b1);
    n_bin <= n_bin + int'(bin_we === 1'b1);
    n_gas <= n_gas + int'(gas_we === 1'b1);
  end
  dac_archive_ctrl dac_archive_ctrl_i (
    .clock, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .service_switch, .binary_in, .primary_volume_count(32'h0000_1234), .base_volume_count(32'h0000_1000),
    .meas_value(meas), .sync_done, .sync_ok, .sync_offset, .stat_rec, .stat_we, .bin_we, .set_we, .set_rec,
    .gas_we, .gas_addr, .bill_we, .sync_req, .time_alert, .sync_timeout_error, .tariff_sel
  );
  dac_svc_model dac_svc_model_i (.clock, .switch_on, .sync_req, .service_switch, .sync_done, .sync_ok, .sync_offset);
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      @(posedge clock);
      n++;
    end
    q = avs_readdata;
    chk(n, 1, "bus answer");
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask : bus
  task automatic req(input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, `DAC_A_REQ, d, q);
    repeat (4) @(posedge clock);
  endtask : req
  task automatic sw(input logic v);
    switch_on <= v;
    repeat (6) @(posedge clock);
  endtask : sw
  task automatic t_gate;
    int s;
    logic [31:0] q;
    bus(1'b0, `DAC_A_STATUS, 32'h0, q);
    chk(q, 32'h0, "status at reset");
    s = n_set;
    req(32'h0000_0001);
    chk(n_set - s, 0, "full off");
    sw(1'b1);
    req(32'h0001_0002);
    chk(n_set - s, 1, "full on");
    chk({24'h0, set_rec.activity}, 32'h2, "activity");
    chk({31'h0, set_rec.metro}, 32'h1, "metro flag");
    bus(1'b1, `DAC_A_CTRL, 32'h0000_0002, q);
    sw(1'b0);
    s = n_set;
    req(32'h0001_0003);
    chk(n_set - s, 0, "partial metro");
    req(32'h0000_0004);
    chk(n_set - s, 1, "partial plain");
    sw(1'b1);
    bus(1'b1, `DAC_A_CTRL, 32'h0000_0001, q);
    sw(1'b0);
    s = n_set;
    req(32'h0001_0005);
    chk(n_set - s, 1, "none metro");
    $display("test gate done");
  endtask : t_gate
  task automatic t_limit;
    logic [31:0] q;
    meas <= 32'h0000_0100;
    bus(1'b1, `DAC_A_CTRL, 32'h0000_0401, q);
    bus(1'b1, `DAC_A_CTRL, 32'h0000_0001, q);
    bus(1'b0, `DAC_A_MIN, 32'h0, q);
    chk(q, 32'h0000_0100, "min init");
    bus(1'b0, `DAC_A_MAX, 32'h0, q);
    chk(q, 32'h0000_0100, "max init");
    meas <= 32'h0000_0200;
    repeat (3) @(posedge clock);
    bus(1'b0, `DAC_A_MAX, 32'h0, q);
    chk(q, 32'h0000_0200, "max track");
    meas <= 32'h0000_0050;
    repeat (3) @(posedge clock);
    bus(1'b0, `DAC_A_MIN, 32'h0, q);
    chk(q, 32'h0000_0050, "min track");
    $display("test limit done");
  endtask : t_limit
  task automatic t_bin;
    int s;
    s = n_bin;
    binary_in <= 8'h05;
    repeat (5) @(posedge clock);
    chk(n_bin - s, 1, "one change");
    binary_in <= 8'h04;
    @(posedge clock);
    binary_in <= 8'h06;
    repeat (10) @(posedge clock);
    chk(n_bin - s, 3, "back to back");
    chk(stat_rec.status[31:0], 32'h0000_0006, "status bits");
    chk(stat_rec.primary_volume_count, 32'h0000_1234, "status volume");
    $display("test binary done");
  endtask : t_bin
  task automatic t_gas;
    int s, t;
    logic [3:0] g;
    logic [31:0] q;
    s = n_gas;
    t = n_set;
    g = gas_addr;
    for (int i = 0; i < 17; i++) begin
      req(32'h0002_0006);
    end
    chk(n_gas - s, 17, "gas count");
    chk(n_set - t, 0, "gas in settings");
    chk({28'h0, gas_addr}, {28'h0, g}, "gas wrap");
    bus(1'b0, `DAC_A_GAS_PTR, 32'h0, q);
    chk(q, {28'h0, g + 4'h1}, "gas ptr");
    bus(1'b0, `DAC_A_STATUS, 32'h0, q);
    chk({31'h0, q[5]}, 32'h1, "wrap flag");
    bus(1'b1, `DAC_A_TARIFF, 32'h0001_0000, q);
    @(posedge clock);
    chk({30'h0, tariff_sel}, 32'h0000_0001, "second schedule");
    $display("test gas done");
  endtask : t_gas
  task automatic t_tcorr;
    int s, t;
    logic [31:0] q, tm;
    logic [31:0] dv[5] = '{32'h0000_001E, 32'h0000_012C, 32'h0000_03E8, 32'hFFFF_FC18, 32'h0000_1F40};
    int es[5] = '{0, 0, 1, 1, 0};
    int et[5] = '{0, 1, 1, 1, 1};
    chk({31'h0, time_alert}, 32'h0, "early alert");
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, `DAC_A_TCORR, dv[i], q);
      bus(1'b0, `DAC_A_TIME, 32'h0, tm);
      s = n_set;
      t = n_stat;
      req(32'h0004_0000);
      chk(n_set - s, es[i], "corr settings");
      chk(n_stat - t, et[i], "corr status");
      bus(1'b0, `DAC_A_TIME, 32'h0, q);
      chk(q, (i < 4) ? tm + dv[i] : tm, "corr applied");
    end
    bus(1'b0, `DAC_A_TIME, 32'h0, q);
    chk(q, tm, "time kept");
    chk({31'h0, time_alert}, 32'h1, "alert");
    $display("test time done");
  endtask : t_tcorr
  task automatic t_fill;
    int s;
    logic [31:0] q;
    for (int i = 0; i < 300 && n_set < 256; i++) begin
      req(32'h0000_0007);
    end
    s = n_set;
    req(32'h0000_0008);
    chk(n_set, 256, "depth");
    chk(n_set - s, 0, "full refuses");
    bus(1'b0, `DAC_A_STATUS, 32'h0, q);
    chk({31'h0, q[2]}, 32'h1, "full flag");
    $display("test fill done");
  endtask : t_fill
  task automatic summarize;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    t_gate();
    t_limit();
    t_bin();
    t_gas();
    t_tcorr();
    t_fill();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    $display("wrong value at %0t: watchdog", $time);
    summarize();
  end
endmodule : tb
bind dac_archive_ctrl dac_asserts dac_asserts_i (
  .clock, .rst_b, .avs_read, .avs_write, .avs_waitrequest, .binary_in, .bin_we, .set_we,
  .gas_we, .gas_addr, .time_alert, .sync_done, .sync_ok, .sync_timeout_error
);
`default_nettype wire
